// ==== core/charger_supervisor_consts.svh ====
// Offsets, field positions, reset values and timing counts of the supervisor.
`ifndef CHARGER_SUPERVISOR_CONSTS_SVH
`define CHARGER_SUPERVISOR_CONSTS_SVH
`define CLK_HZ             25000000
`define TICK_US            1000
`define TICK_CYCLES        ((`CLK_HZ / 1000000) * `TICK_US)
`define EVENT_PULSE_US     256
`define EVENT_PULSE_CYCLES ((`CLK_HZ / 1000000) * `EVENT_PULSE_US)
`define WATCH_S            50
`define WATCH_TICKS        (`WATCH_S * 1000000 / `TICK_US)
`define SAFE_MIN_0         45
`define SAFE_MIN_1         360
`define SAFE_MIN_2         540
`define TICKS_PER_MIN      (60 * 1000000 / `TICK_US)
`define SHORT_DEGLITCH_MS  64
`define SHORT_TICKS        (`SHORT_DEGLITCH_MS * 1000 / `TICK_US)
`define REG_STATUS         4'h0
`define REG_CONTROL        4'h4
`define ST_WATCH_FLAG      7
`define ST_WATCH_EN        6
`define CT_CHARGE_DIS      0
`define CT_TEST_MODE       1
`define CT_SAFE_LO         2
`define SAFE_OFF           2'h3
`define SAFE_SEL_RESET     2'h1
`define PRESC_W            15
`define WATCH_W            16
`define SAFE_W             25
`define PULSE_W            13
`define SHORT_W            7
`define COND_N             19
`define C_SRC              0
`define C_OVP              1
`define C_UNDERVOLTAGE_LOCKOUT             2
`define C_SLEEP            3
`define C_TEMP_STOP        4
`define C_TEMP_REDUCE      5
`define C_DIE_HOT          6
`define C_DIE_COOLED       7
`define C_BAT_OVP          8
`define C_SYS_SHORT        9
`define C_BAT_OK           10
`define C_THERM_REG        11
`define C_IN_LIMIT         12
`define C_MIN_SYS          13
`define C_SUPPLEMENT       14
`define C_BAT_PRESENT      15
`define C_PROG_SHORT       16
`define C_IN_GOOD          17
`define C_TERM             18
`define F_TIMER            6
`endif

// ==== core/charger_supervisor_pkg.sv ====
// Types of the charger supervisor.
`default_nettype none
`include "charger_supervisor_consts.svh"
package charger_supervisor_pkg;
  typedef enum logic [2:0] {
    st_idle, st_charge, st_done, st_suspend, st_shutdown
  } charge_state_t;

  typedef struct packed {
    logic [`COND_N-1:0]  sync1;
    logic [`COND_N-1:0]  sync2;
    logic [`COND_N-1:0]  prev;
    logic [`PRESC_W-1:0] presc;
    logic                tick;
    logic                ack;
    logic [31:0]         readdata;
    logic [3:0]          rd_code;
    logic [`WATCH_W-1:0] wd_cnt;
    logic                host_watch_enable;
    logic                wd_run;
    logic                wd_flag;
    logic                default_mode;
    logic                charge_dis;
    logic                test_mode;
    logic [1:0]          safe_sel;
    charge_state_t       st;
    logic [`SAFE_W-1:0]  safe_cnt;
    logic [9:0]          pending;
    logic [`PULSE_W-1:0] pulse_cnt;
    logic                short_off;
    logic [`SHORT_W-1:0] short_cnt;
  } sup_state_t;
endpackage
`default_nettype wire

// ==== core/charger_supervisor_timers.sv ====
// Charge sequencing, host watchdog, safety timer and fault supervision.
// Operation
// - Start charging when a valid source is present and charging is enabled.
// - Host watchdog times out fifty seconds after the last host write.
// - Each completed register write clears the watchdog count and starts it.
// - Watchdog enable bit zero stops it; one enables and restarts it.
// - Watchdog expiry reloads default parameters; charging carries on.
// - Host may restart after expiry, but a safety expiry keeps charging off.
// - Safety timer starts with charging and runs throughout it.
// - Safety expiry before termination suspends charging.
// - Host selects the safety timer duration through a register.
// - Safety expiry gives one 256 us low pulse on both pins, sets fault.
// - Safety timer counts double in precharge, regulation, reduction, limiting.
// - Safety timer holds count in overvoltage, thermistor stop, shutdown, sleep.
// - Die overheat stops converter, holds timers, pulses pins, sets fault.
// - After thermal shutdown a new cycle starts once the die has cooled.
// - Battery overvoltage stops converter, turns battery switch on, reports.
// - Battery-only output short opens the switch per deglitch, then retests.
// - Battery-only system output requires battery above lockout threshold.
// - Overload at zero charge current enters supplement with switch on.
// - Test mode is refused with a battery present; it disables input limit.
// - Input faults disable output and charging; lockout resets the timer.
// - Battery-side faults keep output, stop charging; timer fault resets.
// - Faults read as a four-bit code, one per read, then normal.
// - Watchdog fault flag reads one after an enabled watchdog timeout.
//
// Chosen here: the address map and register access over Avalon-MM.
`default_nettype none
`include "charger_supervisor_consts.svh"
module charger_supervisor_timers
  import charger_supervisor_pkg::*;
#(
  parameter int TICK_CYCLES  = `TICK_CYCLES,
  parameter int PULSE_CYCLES = `EVENT_PULSE_CYCLES,
  parameter int WATCH_TICKS  = `WATCH_TICKS,
  parameter int SAFE_TICKS_0 = `SAFE_MIN_0 * `TICKS_PER_MIN,
  parameter int SAFE_TICKS_1 = `SAFE_MIN_1 * `TICKS_PER_MIN,
  parameter int SAFE_TICKS_2 = `SAFE_MIN_2 * `TICKS_PER_MIN
) (
  input  wire logic        clk,                     // 25 MHz clock
  input  wire logic        sys_rst,                 // Synchronous reset
  input  wire logic [3:0]  avs_address,             // Byte address
  input  wire logic        avs_read,                // Read request
  input  wire logic        avs_write,               // Write request
  input  wire logic [31:0] avs_writedata,           // Write data
  output logic [31:0]      avs_readdata,            // Read data
  output logic             avs_waitrequest,         // Stall
  input  wire logic        source_valid,            // Input source good
  input  wire logic        overvoltage_protection,  // Input over limit
  input  wire logic        undervoltage_lockout,    // Input under lockout
  input  wire logic        sleep_condition,         // Input below battery
  input  wire logic        thermistor_stop,         // Battery temp, charge off
  input  wire logic        thermistor_reduce,       // Battery temp, reduced
  input  wire logic        thermal_shutdown_limit,  // Die above shutdown
  input  wire logic        die_cooled,              // Die 10 C below shutdown
  input  wire logic        battery_overvoltage,     // Battery 5 % over target
  input  wire logic        system_output_short,     // Output short limit hit
  input  wire logic        battery_lockout_ok,      // Battery above lockout
  input  wire logic        thermal_regulation,      // Die regulation active
  input  wire logic        input_current_limiting,  // Input limit active
  input  wire logic        minimum_system_voltage,  // Precharge or min system
  input  wire logic        dynamic_load_sharing,    // Overload at zero charge
  input  wire logic        battery_present,         // Detection found battery
  input  wire logic        program_pin_short,       // Current-set pin short
  input  wire logic        input_good_fault,        // Input fault, regulator low
  input  wire logic        charge_terminated,       // Charge termination
  output logic             converter_enable,        // Buck converter on
  output logic             charge_enable,           // Charge current on
  output logic             system_output_enable,    // System output on
  output logic             battery_switch_on,       // Battery switch closed
  output logic             default_mode,            // Defaults in force
  output logic             production_test_mode,    // Test mode active
  output logic             input_limit_disable,     // Input limit off
  output logic             host_watch_expired_flag, // Watchdog fault flag
  output logic             stat_pin_out,            // Open-drain level
  output logic             stat_pin_oe_n,           // Low while pulling
  output logic             alert_pin_out,           // Open-drain level
  output logic             alert_pin_oe_n           // Low while pulling
);
  sup_state_t         s;
  sup_state_t         n;
  logic [`COND_N-1:0] raw;
  logic [`COND_N-1:0] c;
  logic               req;
  logic               wr_done;
  logic               rd_done;
  logic               held;
  logic               double_rate;
  logic               in_fault;
  logic [3:0]         code;
  logic [1:0]         stat;
  logic [9:0]         fault_set;

  // Bit i of the fault queue reads as code i + 1; the lowest set bit is
  // shown first, so the most basic input fault is always reported first.
  function automatic logic [3:0] lowest_code(input logic [9:0] p);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 9; i >= 0; i--) begin
      if (p[i]) begin
        r = 4'(i + 1);
      end
    end
    return r;
  endfunction

  // Safety limit in ticks per duration select; the off code never reaches
  // it because the counter does not run then.
  function automatic logic [`SAFE_W-1:0] safe_limit(input logic [1:0] sel);
    logic [`SAFE_W-1:0] r;
    r = `SAFE_W'(SAFE_TICKS_1);
    if (sel == 2'h0) begin
      r = `SAFE_W'(SAFE_TICKS_0);
    end else if (sel == 2'h2) begin
      r = `SAFE_W'(SAFE_TICKS_2);
    end
    return r;
  endfunction

  // Condition pins arrive from the analog side with no relation to clk.
  // Only the second synchroniser stage feeds logic, so a metastable first
  // stage is never decoded.
  assign raw = {charge_terminated, input_good_fault, program_pin_short,
                battery_present, dynamic_load_sharing, minimum_system_voltage,
                input_current_limiting, thermal_regulation, battery_lockout_ok,
                system_output_short, battery_overvoltage, die_cooled,
                thermal_shutdown_limit, thermistor_reduce, thermistor_stop,
                sleep_condition, undervoltage_lockout, overvoltage_protection,
                source_valid};
  assign c       = s.sync2;
  assign req     = avs_read | avs_write;
  assign wr_done = avs_write & s.ack;
  assign rd_done = avs_read & s.ack;
  assign code    = lowest_code(s.pending);
  // Conditions that freeze the safety count without clearing it. Lockout
  // is left out on purpose: it clears the count instead.
  assign held    = c[`C_OVP] | c[`C_SLEEP] | c[`C_TEMP_STOP] | c[`C_DIE_HOT]
                 | ~c[`C_BAT_PRESENT] | c[`C_PROG_SHORT]
                 | c[`C_IN_GOOD];
  assign double_rate = c[`C_MIN_SYS] | c[`C_THERM_REG] | c[`C_TEMP_REDUCE]
                     | c[`C_IN_LIMIT];
  assign in_fault = c[`C_OVP] | c[`C_UNDERVOLTAGE_LOCKOUT] | c[`C_SLEEP] | c[`C_IN_GOOD]
                  | (s.st == st_shutdown);
  // Live fault levels; the timer fault is an event and is set by the
  // charge sequence instead.
  assign fault_set = {c[`C_IN_GOOD], c[`C_PROG_SHORT], ~c[`C_BAT_PRESENT],
                      1'b0, c[`C_DIE_HOT], c[`C_BAT_OVP], c[`C_TEMP_STOP],
                      c[`C_SLEEP], c[`C_UNDERVOLTAGE_LOCKOUT], c[`C_OVP]};

  // Charge state field: ready, charging, done or fault.
  always_comb begin
    if (s.st == st_charge) begin
      stat = 2'h1;
    end else if (s.st == st_done) begin
      stat = 2'h2;
    end else if (s.pending != 10'h0 || s.st == st_suspend
                 || s.st == st_shutdown) begin
      stat = 2'h3;
    end else begin
      stat = 2'h0;
    end
  end

  always_comb begin
    n = s;
    n.sync1 = raw;
    n.sync2 = s.sync1;
    // Previous synchronised levels feed the die-overheat edge detector.
    n.prev  = s.sync2;
    // Prescaled tick shared by the watchdog, safety and short-retest timers.
    n.tick = 1'b0;
    if (s.presc == `PRESC_W'(TICK_CYCLES - 1)) begin
      n.presc = '0;
      n.tick  = 1'b1;
    end else begin
      n.presc = s.presc + `PRESC_W'(1);
    end
    // Bus: first cycle of a request stalls and prepares read data. Every
    // request takes exactly one wait cycle, and unmapped addresses simply
    // read as zero.
    n.ack = req & ~s.ack;
    if (req && !s.ack) begin
      n.rd_code = code;
      if (avs_address == `REG_STATUS) begin
        n.readdata = {24'h0, s.wd_flag, s.host_watch_enable, stat, code};
      end else if (avs_address == `REG_CONTROL) begin
        n.readdata = {28'h0, s.safe_sel, s.test_mode, s.charge_dis};
      end else begin
        n.readdata = 32'h0;
      end
    end
    // Fault queue: a read pops the code it returned; a live fault re-sets.
    if (rd_done && avs_address == `REG_STATUS) begin
      if (s.rd_code != 4'h0) begin
        n.pending[s.rd_code - 4'h1] = 1'b0;
      end
      n.wd_flag = 1'b0;
    end
    n.pending = n.pending | fault_set;
    // Host watchdog. The expiry is applied after the status read above, so
    // an expiry and a clearing read in one cycle leave the flag set.
    if (s.tick && s.wd_run && s.host_watch_enable) begin
      if (s.wd_cnt == `WATCH_W'(WATCH_TICKS - 1)) begin
        n.wd_run       = 1'b0;
        n.wd_flag      = 1'b1;
        n.default_mode = 1'b1;
        n.charge_dis   = 1'b0;
        n.test_mode    = 1'b0;
        n.safe_sel     = `SAFE_SEL_RESET;
      end else begin
        n.wd_cnt = s.wd_cnt + `WATCH_W'(1);
      end
    end
    if (wr_done) begin
      n.wd_cnt       = '0;
      n.wd_run       = 1'b1;
      // Any write hands control back to the host after an expiry.
      n.default_mode = 1'b0;
      if (avs_address == `REG_STATUS) begin
        n.host_watch_enable  = avs_writedata[`ST_WATCH_EN];
        n.wd_run = avs_writedata[`ST_WATCH_EN];
      end else if (avs_address == `REG_CONTROL) begin
        n.charge_dis = avs_writedata[`CT_CHARGE_DIS];
        n.test_mode  = avs_writedata[`CT_TEST_MODE]
                     & ~c[`C_BAT_PRESENT];
        n.safe_sel   = avs_writedata[`CT_SAFE_LO +: 2];
      end
    end
    // Event pulse width. Loads further down override this step, so a new
    // event always restarts the full width.
    if (s.pulse_cnt != '0) begin
      n.pulse_cnt = s.pulse_cnt - `PULSE_W'(1);
    end
    // Safety timer and charge sequence. A suspended cycle is left only by
    // losing the source, by lockout or by die overheat, so host writes cannot resume it.
    if (s.st == st_charge && !held && s.tick
        && s.safe_sel != `SAFE_OFF) begin
      n.safe_cnt = s.safe_cnt + (double_rate ? `SAFE_W'(2) : `SAFE_W'(1));
    end
    case (s.st)
      st_idle: begin
        if (c[`C_SRC] && !s.charge_dis && !in_fault) begin
          n.st       = st_charge;
          n.safe_cnt = '0;
        end
      end
      st_charge: begin
        if (c[`C_TERM]) begin
          n.st = st_done;
        end else if (s.charge_dis || !c[`C_SRC]) begin
          n.st = st_idle;
        end else if (s.safe_sel != `SAFE_OFF
                     && s.safe_cnt >= safe_limit(s.safe_sel)) begin
          n.st                 = st_suspend;
          n.safe_cnt           = '0;
          n.pending[`F_TIMER]  = 1'b1;
          n.pulse_cnt          = `PULSE_W'(PULSE_CYCLES);
        end
      end
      st_done: begin
        if (!c[`C_SRC]) begin
          n.st = st_idle;
        end
      end
      st_suspend: begin
        if (!c[`C_SRC]) begin
          n.st = st_idle;
        end
      end
      st_shutdown: begin
        if (c[`C_DIE_COOLED] && !c[`C_DIE_HOT]) begin
          n.st       = st_charge;
          n.safe_cnt = '0;
        end
      end
      default: begin
        n.st = st_idle;
      end
    endcase
    if (c[`C_DIE_HOT] && s.st != st_shutdown) begin
      n.st = st_shutdown;
    end
    // The pulse follows the rising edge only, so a lockout that keeps
    // pulling the state back to idle cannot repeat it.
    if (c[`C_DIE_HOT] && !s.prev[`C_DIE_HOT]) begin
      n.pulse_cnt = `PULSE_W'(PULSE_CYCLES);
    end
    if (c[`C_UNDERVOLTAGE_LOCKOUT]) begin
      n.st       = st_idle;
      n.safe_cnt = '0;
    end
    // Battery-only short retest: the switch stays open for one deglitch
    // interval, then closes again to take a new look at the short.
    if (s.short_off) begin
      if (s.tick) begin
        if (s.short_cnt == `SHORT_W'(`SHORT_TICKS - 1)) begin
          n.short_off = 1'b0;
        end else begin
          n.short_cnt = s.short_cnt + `SHORT_W'(1);
        end
      end
    end else if (!c[`C_SRC] && c[`C_SYS_SHORT]) begin
      n.short_off = 1'b1;
      n.short_cnt = '0;
    end
    if (sys_rst) begin
      n              = '0;
      // The watchdog is enabled but stays idle until the first host write.
      n.host_watch_enable        = 1'b1;
      n.safe_sel     = `SAFE_SEL_RESET;
      n.st           = st_idle;
    end
  end

  always_ff @(posedge clk) begin
    s <= n;
  end

  assign avs_waitrequest = req & ~s.ack;
  assign avs_readdata    = s.readdata;
  assign converter_enable = c[`C_SRC] & ~in_fault
                          & ~c[`C_BAT_OVP];
  assign charge_enable = (s.st == st_charge) & ~s.charge_dis & ~held
                       & ~c[`C_BAT_OVP] & ~in_fault;
  assign system_output_enable = c[`C_SRC] ? ~in_fault
                              : (c[`C_BAT_OK] & ~s.short_off);
  assign battery_switch_on = c[`C_BAT_OVP]
                           | (c[`C_SUPPLEMENT] & c[`C_SRC])
                           | (~c[`C_SRC] & c[`C_BAT_OK] & ~s.short_off)
                           | charge_enable;
  assign default_mode            = s.default_mode;
  assign production_test_mode    = s.test_mode;
  assign input_limit_disable     = s.test_mode;
  assign host_watch_expired_flag = s.wd_flag;
  // The event pins are open drain: the level is always low and the enable
  // carries the pulse.
  assign stat_pin_out            = 1'b0;
  assign alert_pin_out           = 1'b0;
  assign stat_pin_oe_n  = (s.pulse_cnt == '0);
  assign alert_pin_oe_n = (s.pulse_cnt == '0);
endmodule
`default_nettype wire

// ==== tb/charger_supervisor_timers_checker.sv ====
// Concurrent checks on the ports of the charger supervisor.
`default_nettype none
module charger_supervisor_timers_checker #(
  parameter int PULSE_CYCLES = 8
) (
  input wire logic clk,                    // Clock
  input wire logic sys_rst,                // Reset
  input wire logic avs_read,               // Read request
  input wire logic avs_write,              // Write request
  input wire logic avs_waitrequest,        // Stall
  input wire logic overvoltage_protection, // Input over limit
  input wire logic thermal_shutdown_limit, // Die too hot
  input wire logic battery_present,        // Battery found
  input wire logic converter_enable,       // Converter on
  input wire logic charge_enable,          // Charging on
  input wire logic system_output_enable,   // Output on
  input wire logic default_mode,           // Defaults in force
  input wire logic production_test_mode,   // Test mode
  input wire logic input_limit_disable,    // Input limit off
  input wire logic host_watch_expired_flag,// Watchdog flag
  input wire logic stat_pin_out,           // Pin level
  input wire logic stat_pin_oe_n,          // Pin pull
  input wire logic alert_pin_out,          // Pin level
  input wire logic alert_pin_oe_n          // Pin pull
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  int unsigned low_n;
  // Counts the cycles for which the event pins have been pulled low.
  always_ff @(posedge clk)
    if (sys_rst || stat_pin_oe_n) low_n <= 0;
    else low_n <= low_n + 1;
  a_pulse_width: assert property ($rose(stat_pin_oe_n) |->
    low_n == PULSE_CYCLES) else $error("event pulse width wrong");
  a_pulse_max: assert property (low_n <= PULSE_CYCLES)
    else $error("event pulse too long");
  a_pins_same: assert property (stat_pin_oe_n == alert_pin_oe_n)
    else $error("event pins differ");
  a_pins_low: assert property (!stat_pin_out && !alert_pin_out)
    else $error("open-drain level not low");
  a_wait_first: assert property ($rose(avs_read || avs_write)
    |-> avs_waitrequest) else $error("no wait cycle");
  a_wait_once: assert property ((avs_read || avs_write)
    && avs_waitrequest |=> !avs_waitrequest) else $error("wait too long");
  a_ovp_off: assert property (overvoltage_protection [*5] |->
    !charge_enable && !system_output_enable) else $error("ovp not off");
  a_hot_off: assert property (thermal_shutdown_limit [*5] |->
    !converter_enable && !charge_enable) else $error("hot not off");
  a_test_limit: assert property (input_limit_disable ==
    production_test_mode) else $error("test limit mismatch");
  a_test_refuse: assert property ($rose(production_test_mode)
    |-> !battery_present) else $error("test mode with battery");
  a_expire_flag: assert property ($rose(default_mode) |->
    host_watch_expired_flag) else $error("flag not set");
  a_keep_charge: assert property ($rose(default_mode) |->
    charge_enable == $past(charge_enable)) else $error("charge cut");
  c_pulse: cover property ($rose(stat_pin_oe_n));
  c_expire: cover property ($rose(default_mode));
  c_test: cover property ($rose(production_test_mode));
endmodule
bind charger_supervisor_timers charger_supervisor_timers_checker #(
  .PULSE_CYCLES(PULSE_CYCLES)) sup_chk (.*);
`default_nettype wire

// ==== tb/host_model.sv ====
// Host processor model that drives the register bus.
`default_nettype none
module host_model (
  input  wire logic        clk,         // Bus clock
  input  wire logic        waitrequest, // Slave stall
  input  wire logic [31:0] readdata,    // Read data
  output logic [3:0]       address,     // Byte address
  output logic             read,        // Read request
  output logic             write,       // Write request
  output logic [31:0]      writedata    // Write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    address <= 4'h0;
    read <= 1'b0;
    write <= 1'b0;
    writedata <= 32'h0;
  end
  // Holds the request until waitrequest is sampled low.
  task automatic xfer(input logic rd, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    ok = (n < 50);
    read <= 1'b0;
    write <= 1'b0;
    writedata <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== tb/charger_supervisor_timers_bench.sv ====
// Self-checking bench of the charger supervisor timers.
`default_nettype none
`include "charger_supervisor_consts.svh"
module charger_supervisor_timers_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4;
  localparam int WT = 20;
  localparam int ST = 10;
  localparam int SH = `SHORT_TICKS * TK;
  logic clk = 1'b0, sys_rst = 1'b1;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic avs_read, avs_write, avs_waitrequest;
  logic source_valid = 1'b0, overvoltage_protection = 1'b0,
    undervoltage_lockout = 1'b0, sleep_condition = 1'b0,
    thermistor_stop = 1'b0, thermistor_reduce = 1'b0,
    thermal_shutdown_limit = 1'b0, die_cooled = 1'b0,
    battery_overvoltage = 1'b0, system_output_short = 1'b0,
    battery_lockout_ok = 1'b0, thermal_regulation = 1'b0,
    input_current_limiting = 1'b0, minimum_system_voltage = 1'b0,
    dynamic_load_sharing = 1'b0, battery_present = 1'b0,
    program_pin_short = 1'b0, input_good_fault = 1'b0,
    charge_terminated = 1'b0;
  logic converter_enable, charge_enable, system_output_enable,
    battery_switch_on, default_mode, production_test_mode,
    input_limit_disable, host_watch_expired_flag, stat_pin_out,
    stat_pin_oe_n, alert_pin_out, alert_pin_oe_n;
  int miscompares = 0, checks_done = 0, ctrl = 4, n;
  logic [31:0] seed = 32'h0657;
  charger_supervisor_timers #(.TICK_CYCLES(TK), .PULSE_CYCLES(8),
    .WATCH_TICKS(WT), .SAFE_TICKS_0(ST), .SAFE_TICKS_1(2 * ST),
    .SAFE_TICKS_2(3 * ST)) uut (.*);
  host_model host (.clk(clk), .waitrequest(avs_waitrequest),
    .readdata(avs_readdata), .address(avs_address), .read(avs_read),
    .write(avs_write), .writedata(avs_writedata));
  always #20 clk = ~clk;
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic complete_run;
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // The model of the control register follows every write.
  task automatic bus(input logic rd, input logic [3:0] a,
    input logic [31:0] d);
    logic ok;
    host.xfer(rd, a, d, q, ok);
    if (!ok) begin
      miscompares++;
      complete_run();
    end
    if (!rd && a == 4'h4) begin
      ctrl = int'(d[3:0]);
      if (battery_present) ctrl[1] = 1'b0;
    end
    @(posedge clk);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n == lim) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic set_dbl(input int k, input logic v);
    case (k)
      1: minimum_system_voltage <= v;
      2: thermal_regulation <= v;
      3: thermistor_reduce <= v;
      4: input_current_limiting <= v;
      default: ;
    endcase
  endtask
  task automatic safe_run(input int k);
    int e;
    e = (k == 0) ? ST * TK : ST * TK / 2;
    source_valid <= 1'b0;
    cyc(8);
    set_dbl(k, 1'b1);
    source_valid <= 1'b1;
    wait_for(stat_pin_oe_n, 1'b0, 200);
    chk(32'(n inside {[e - TK : e + 8]}), 32'h1);
    cyc(12);
    chk(charge_enable, 1'b0);
    bus(1'b1, 4'h0, 32'h0);
    chk(q[5:0], 32'h37);
    set_dbl(k, 1'b0);
  endtask
  initial begin
    cyc(10);
    sys_rst <= 1'b0;
    cyc(2);
    bus(1'b1, 4'h0, 32'h0);
    chk(q[7:6], 32'h1);
    bus(1'b1, 4'h4, 32'h0);
    chk(q, ctrl);
    bus(1'b0, 4'h0, 32'h0);
    battery_present <= 1'b1;
    battery_lockout_ok <= 1'b1;
    cyc(4);
    bus(1'b0, 4'h4, 32'h2);
    chk(production_test_mode, 1'b0);
    battery_present <= 1'b0;
    cyc(4);
    bus(1'b0, 4'h4, 32'h2);
    chk(input_limit_disable, 1'b1);
    bus(1'b0, 4'h8, xorshift());
    bus(1'b1, 4'h8, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 4'h4, 32'h0);
    chk(q, ctrl);
    battery_present <= 1'b1;
    bus(1'b0, 4'h4, 32'hc);
    source_valid <= 1'b1;
    bus(1'b0, 4'h0, 32'h40);
    cyc(20 + int'(xorshift() % 40));
    bus(1'b0, 4'h0, 32'h40);
    cyc(WT * TK - 12);
    chk(default_mode, 1'b0);
    wait_for(default_mode, 1'b1, 30);
    chk(32'(n inside {[4 : 24]}), 32'h1);
    chk(charge_enable, 1'b1);
    ctrl = 4;
    bus(1'b1, 4'h4, 32'h0);
    chk(q, ctrl);
    bus(1'b1, 4'h0, 32'h0);
    chk(q[7:6], 32'h3);
    bus(1'b1, 4'h0, 32'h0);
    chk(q[7], 1'b0);
    bus(1'b0, 4'h0, 32'h0);
    cyc(WT * TK + 20);
    chk(default_mode, 1'b0);
    bus(1'b0, 4'h4, 32'h0);
    for (int k = 0; k < 5; k++) safe_run(k);
    bus(1'b0, 4'h4, 32'hc);
    source_valid <= 1'b0;
    cyc(8);
    source_valid <= 1'b1;
    cyc(8);
    chk(charge_enable, 1'b1);
    overvoltage_protection <= 1'b1;
    cyc(8);
    chk(system_output_enable, 1'b0);
    overvoltage_protection <= 1'b0;
    thermal_shutdown_limit <= 1'b1;
    wait_for(stat_pin_oe_n, 1'b0, 12);
    chk(converter_enable, 1'b0);
    cyc(12);
    thermal_shutdown_limit <= 1'b0;
    cyc(8);
    chk(charge_enable, 1'b0);
    die_cooled <= 1'b1;
    cyc(8);
    chk(charge_enable, 1'b1);
    battery_overvoltage <= 1'b1;
    cyc(4);
    chk(battery_switch_on, 1'b1);
    chk(converter_enable, 1'b0);
    battery_overvoltage <= 1'b0;
    source_valid <= 1'b0;
    cyc(4);
    chk(system_output_enable, 1'b1);
    system_output_short <= 1'b1;
    cyc(4);
    chk(battery_switch_on, 1'b0);
    system_output_short <= 1'b0;
    wait_for(battery_switch_on, 1'b1, 300);
    chk(32'(n inside {[SH - 4 : SH]}), 32'h1);
    complete_run();
  end
endmodule
`default_nettype wire
